// ---- rtl/qsuf_pkg.sv ----
// package: register map, field layout and reset values of the queue split and forward config
package qsuf_pkg;

    // ========================================================================
    // register offsets
    localparam logic [7:0] QSUF_ADDR_SPLIT = 8'h82;
    localparam logic [7:0] QSUF_ADDR_UU    = 8'h83;
    localparam logic [7:0] QSUF_ADDR_UM    = 8'h84;

    // ========================================================================
    // field positions
    localparam int QSUF_SEL_MSB = 7;
    localparam int QSUF_SEL_LSB = 6;
    localparam int QSUF_EN_BIT  = 5;
    localparam int QSUF_MAP_MSB = 4;
    localparam int QSUF_MAP_LSB = 0;

    // ========================================================================
    // reset values of writable fields and fixed values of reserved fields
    localparam logic [1:0] QSUF_SEL_RST   = 2'h2;
    localparam logic       QSUF_EN_RST    = 1'h0;
    localparam logic [4:0] QSUF_MAP_RST   = 5'h00;
    localparam logic [5:0] QSUF_SPLIT_RSV = 6'h08;
    localparam logic [1:0] QSUF_UU_RSV    = 2'h2;
    localparam logic [1:0] QSUF_UM_RSV    = 2'h1;

    // ========================================================================
    // port map encodings
    localparam logic [4:0] QSUF_MAP_NONE = 5'h00;
    localparam logic [4:0] QSUF_MAP_ALL  = 5'h1F;

    // ========================================================================
    // queue split encodings and priority results
    localparam logic [1:0] QSUF_SPLIT_TOP  = 2'h0;
    localparam logic [1:0] QSUF_SPLIT_HALF = 2'h2;
    localparam logic [1:0] QSUF_SPLIT_BOT  = 2'h3;
    localparam logic [1:0] QSUF_PRIO_1     = 2'h1;
    localparam logic [1:0] QSUF_PRIO_2     = 2'h2;
    localparam logic [1:0] QSUF_PRIO_3     = 2'h3;
    localparam logic [7:0] QSUF_RD_IDLE    = 8'h00;

    typedef enum logic [1:0] {
        QSUF_REG_NONE,
        QSUF_REG_SPLIT,
        QSUF_REG_UU,
        QSUF_REG_UM
    } qsuf_reg_sel_t;

endpackage

// ---- rtl/qsuf_fwd_if.sv ----
// interface: one unknown-destination forward policy between config and decision logic
`timescale 1ns/100ps
`default_nettype none

interface qsuf_fwd_if;
    logic       lookup;
    logic       enable;
    logic [4:0] port_map;
    logic       fwd_valid;
    logic [4:0] fwd_map;
    logic       fwd_drop;

    modport cfg (
        output lookup,
        output enable,
        output port_map,
        input  fwd_valid,
        input  fwd_map,
        input  fwd_drop
    );

    modport dec (
        input  lookup,
        input  enable,
        input  port_map,
        output fwd_valid,
        output fwd_map,
        output fwd_drop
    );
endinterface

`default_nettype wire

// ---- rtl/qsuf_fwd_decide.sv ----
// module: turns one forward policy into a registered egress port set per lookup
`timescale 1ns/100ps
`default_nettype none

module qsuf_fwd_decide (
    input  wire logic clk,
    input  wire logic rst,
    qsuf_fwd_if.dec   fw
);
    import qsuf_pkg::*;

    logic       valid_reg;
    logic       valid_next;
    logic [4:0] map_reg;
    logic [4:0] map_next;
    logic       drop_reg;
    logic       drop_next;

    // ========================================================================
    // decision
    // a disabled policy leaves such frames to normal flooding
    always_comb begin
        valid_next = fw.lookup;
        map_next   = QSUF_MAP_NONE;
        drop_next  = 1'b0;
        if (fw.lookup) begin
            if (fw.enable) begin
                map_next  = fw.port_map;
                drop_next = (fw.port_map == QSUF_MAP_NONE);
            end else begin
                map_next  = QSUF_MAP_ALL;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            valid_reg <= 1'b0;
            map_reg   <= QSUF_MAP_NONE;
            drop_reg  <= 1'b0;
        end else begin
            valid_reg <= valid_next;
            map_reg   <= map_next;
            drop_reg  <= drop_next;
        end
    end

    assign fw.fwd_valid = valid_reg;
    assign fw.fwd_map   = map_reg;
    assign fw.fwd_drop  = drop_reg;

    // ========================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_map_applied: assert property (
        fw.lookup && fw.enable |=> fw.fwd_valid && fw.fwd_map == $past(fw.port_map))
        else $error("enabled lookup did not forward to programmed ports");
    a_map_drop: assert property (
        fw.lookup && fw.enable && fw.port_map == QSUF_MAP_NONE
        |=> fw.fwd_drop && fw.fwd_map == QSUF_MAP_NONE)
        else $error("empty map did not drop the frame");
    a_flood_full: assert property (
        fw.lookup && fw.enable && fw.port_map == QSUF_MAP_ALL
        |=> fw.fwd_map == QSUF_MAP_ALL && !fw.fwd_drop)
        else $error("full map did not flood all five ports");
    a_disabled_flood: assert property (
        fw.lookup && !fw.enable |=> fw.fwd_map == QSUF_MAP_ALL && !fw.fwd_drop)
        else $error("disabled policy changed normal forwarding");
    a_valid_pulse: assert property (
        !fw.lookup |=> !fw.fwd_valid && fw.fwd_map == QSUF_MAP_NONE)
        else $error("forward answer without a lookup");

endmodule

`default_nettype wire

// ---- rtl/qsuf_cfg.sv ----
// module: queue split and unknown-destination forward configuration registers
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module qsuf_cfg (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    input  wire logic       two_queue_mode,
    input  wire logic       prio_valid,
    input  wire logic [1:0] prio_result,
    output logic            queue_valid,
    output logic            queue_high,
    input  wire logic       uu_lookup,
    output logic            uu_valid,
    output logic      [4:0] uu_port_map,
    output logic            uu_drop,
    input  wire logic       um_lookup,
    output logic            um_valid,
    output logic      [4:0] um_port_map,
    output logic            um_drop
);
    import qsuf_pkg::*;

    // ========================================================================
    // register state
    logic [1:0]    split_sel_reg;
    logic [1:0]    split_sel_next;
    logic          uu_en_reg;
    logic          uu_en_next;
    logic [4:0]    uu_map_reg;
    logic [4:0]    uu_map_next;
    logic          um_en_reg;
    logic          um_en_next;
    logic [4:0]    um_map_reg;
    logic [4:0]    um_map_next;
    logic [7:0]    rd_data_reg;
    logic [7:0]    rd_data_next;
    qsuf_reg_sel_t reg_sel;

    // ========================================================================
    // queue fold state
    logic          queue_valid_reg;
    logic          queue_valid_next;
    logic          queue_high_reg;
    logic          queue_high_next;
    logic          queue_split_bit;

    qsuf_fwd_if uu_if ();
    qsuf_fwd_if um_if ();

    // ========================================================================
    // address decode
    always_comb begin
        case (addr)
            QSUF_ADDR_SPLIT: begin
                reg_sel = QSUF_REG_SPLIT;
            end
            QSUF_ADDR_UU: begin
                reg_sel = QSUF_REG_UU;
            end
            QSUF_ADDR_UM: begin
                reg_sel = QSUF_REG_UM;
            end
            default: begin
                reg_sel = QSUF_REG_NONE;
            end
        endcase
    end

    // ========================================================================
    // register writes and reads
    // reserved bits hold no storage, so writes to them simply vanish
    always_comb begin
        split_sel_next = split_sel_reg;
        uu_en_next     = uu_en_reg;
        uu_map_next    = uu_map_reg;
        um_en_next     = um_en_reg;
        um_map_next    = um_map_reg;
        rd_data_next   = QSUF_RD_IDLE;
        if (wr_en) begin
            case (reg_sel)
                QSUF_REG_SPLIT: begin
                    // code 01 is stored as written; its fold is not defined
                    split_sel_next = wr_data[QSUF_SEL_MSB:QSUF_SEL_LSB];
                end
                QSUF_REG_UU: begin
                    uu_en_next  = wr_data[QSUF_EN_BIT];
                    uu_map_next = wr_data[QSUF_MAP_MSB:QSUF_MAP_LSB];
                end
                QSUF_REG_UM: begin
                    um_en_next  = wr_data[QSUF_EN_BIT];
                    um_map_next = wr_data[QSUF_MAP_MSB:QSUF_MAP_LSB];
                end
                default: begin
                    split_sel_next = split_sel_reg;
                end
            endcase
        end
        if (rd_en) begin
            case (reg_sel)
                QSUF_REG_SPLIT: begin
                    rd_data_next = {split_sel_reg, QSUF_SPLIT_RSV};
                end
                QSUF_REG_UU: begin
                    rd_data_next = {QSUF_UU_RSV, uu_en_reg, uu_map_reg};
                end
                QSUF_REG_UM: begin
                    rd_data_next = {QSUF_UM_RSV, um_en_reg, um_map_reg};
                end
                default: begin
                    rd_data_next = QSUF_RD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            split_sel_reg <= QSUF_SEL_RST;
            uu_en_reg     <= QSUF_EN_RST;
            uu_map_reg    <= QSUF_MAP_RST;
            um_en_reg     <= QSUF_EN_RST;
            um_map_reg    <= QSUF_MAP_RST;
            rd_data_reg   <= QSUF_RD_IDLE;
        end else begin
            split_sel_reg <= split_sel_next;
            uu_en_reg     <= uu_en_next;
            uu_map_reg    <= uu_map_next;
            um_en_reg     <= um_en_next;
            um_map_reg    <= um_map_next;
            rd_data_reg   <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;

    // ========================================================================
    // two-queue fold
    // results 1 and 2 each take one select bit; 0 is always low, 3 always high
    always_comb begin
        case (prio_result)
            QSUF_PRIO_1: begin
                queue_split_bit = split_sel_reg[0];
            end
            QSUF_PRIO_2: begin
                queue_split_bit = split_sel_reg[1];
            end
            QSUF_PRIO_3: begin
                queue_split_bit = 1'b1;
            end
            default: begin
                queue_split_bit = 1'b0;
            end
        endcase
        queue_valid_next = prio_valid && two_queue_mode;
        queue_high_next  = queue_valid_next && queue_split_bit;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            queue_valid_reg <= 1'b0;
            queue_high_reg  <= 1'b0;
        end else begin
            queue_valid_reg <= queue_valid_next;
            queue_high_reg  <= queue_high_next;
        end
    end

    assign queue_valid = queue_valid_reg;
    assign queue_high  = queue_high_reg;

    // ========================================================================
    // unknown-destination forward decisions
    assign uu_if.lookup   = uu_lookup;
    assign uu_if.enable   = uu_en_reg;
    assign uu_if.port_map = uu_map_reg;
    assign um_if.lookup   = um_lookup;
    assign um_if.enable   = um_en_reg;
    assign um_if.port_map = um_map_reg;

    qsuf_fwd_decide u_uu_decide (
        .clk (clk),
        .rst (rst),
        .fw  (uu_if.dec)
    );

    qsuf_fwd_decide u_um_decide (
        .clk (clk),
        .rst (rst),
        .fw  (um_if.dec)
    );

    assign uu_valid    = uu_if.fwd_valid;
    assign uu_port_map = uu_if.fwd_map;
    assign uu_drop     = uu_if.fwd_drop;
    assign um_valid    = um_if.fwd_valid;
    assign um_port_map = um_if.fwd_map;
    assign um_drop     = um_if.fwd_drop;

    // ========================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_split_top_only: assert property (
        prio_valid && two_queue_mode && split_sel_reg == QSUF_SPLIT_TOP
        |=> queue_valid && queue_high == ($past(prio_result) == QSUF_PRIO_3))
        else $error("split 00 misplaced a frame");
    a_split_half: assert property (
        prio_valid && two_queue_mode && split_sel_reg == QSUF_SPLIT_HALF
        |=> queue_valid && queue_high == ($past(prio_result) >= QSUF_PRIO_2))
        else $error("split 10 misplaced a frame");
    a_split_bottom_low: assert property (
        prio_valid && two_queue_mode && split_sel_reg == QSUF_SPLIT_BOT
        |=> queue_valid && queue_high == ($past(prio_result) != 2'h0))
        else $error("split 11 misplaced a frame");
    a_queue_idle: assert property (
        !(prio_valid && two_queue_mode) |=> !queue_valid && !queue_high)
        else $error("queue answer outside two-queue lookup");
    a_split_write: assert property (
        wr_en && addr == QSUF_ADDR_SPLIT
        |=> split_sel_reg == $past(wr_data[QSUF_SEL_MSB:QSUF_SEL_LSB]))
        else $error("split select not taken from write");
    a_uu_enable_write: assert property (
        wr_en && addr == QSUF_ADDR_UU |=> uu_en_reg == $past(wr_data[QSUF_EN_BIT]))
        else $error("unicast enable not taken from bit 5");
    a_um_enable_write: assert property (
        wr_en && addr == QSUF_ADDR_UM |=> um_en_reg == $past(wr_data[QSUF_EN_BIT]))
        else $error("multicast enable not taken from bit 5");
    a_reserved_read: assert property (
        rd_en && addr == QSUF_ADDR_UU |=> rd_data[7:6] == QSUF_UU_RSV
        ##0 rd_data[QSUF_MAP_MSB:QSUF_MAP_LSB] == uu_map_reg)
        else $error("unicast register read back wrong");
    a_split_rsv_read: assert property (
        rd_en && addr == QSUF_ADDR_SPLIT ##1 !wr_en
        |-> rd_data == {split_sel_reg, QSUF_SPLIT_RSV})
        else $error("split register read back wrong");
    a_read_only_once: assert property (
        !rd_en |=> rd_data == QSUF_RD_IDLE)
        else $error("read data present without a read");

    // ========================================================================
    // field storage checks
    // unmapped and reserved writes must leave every stored field alone
    a_uu_map_write: assert property (
        wr_en && addr == QSUF_ADDR_UU
        |=> uu_map_reg == $past(wr_data[QSUF_MAP_MSB:QSUF_MAP_LSB]))
        else $error("unicast map not taken from write");
    a_um_map_write: assert property (
        wr_en && addr == QSUF_ADDR_UM
        |=> um_map_reg == $past(wr_data[QSUF_MAP_MSB:QSUF_MAP_LSB]))
        else $error("multicast map not taken from write");
    a_split_hold: assert property (
        !(wr_en && addr == QSUF_ADDR_SPLIT)
        |=> split_sel_reg == $past(split_sel_reg))
        else $error("split select changed without a write");
    a_uu_hold: assert property (
        !(wr_en && addr == QSUF_ADDR_UU)
        |=> uu_en_reg == $past(uu_en_reg) && uu_map_reg == $past(uu_map_reg))
        else $error("unicast fields changed without a write");
    a_um_hold: assert property (
        !(wr_en && addr == QSUF_ADDR_UM)
        |=> um_en_reg == $past(um_en_reg) && um_map_reg == $past(um_map_reg))
        else $error("multicast fields changed without a write");
    a_um_read_back: assert property (
        rd_en && addr == QSUF_ADDR_UM
        |=> rd_data == {QSUF_UM_RSV, $past(um_en_reg), $past(um_map_reg)})
        else $error("multicast register read back wrong");
    a_unmapped_read: assert property (
        rd_en && reg_sel == QSUF_REG_NONE |=> rd_data == QSUF_RD_IDLE)
        else $error("unmapped address returned data");
    a_reset_values: assert property (
        $fell(rst) |-> split_sel_reg == QSUF_SEL_RST
        && uu_en_reg == QSUF_EN_RST && um_en_reg == QSUF_EN_RST)
        else $error("configuration not at reset values after reset");
    // result 0 and result 3 never depend on the split code
    a_result3_high: assert property (
        prio_valid && two_queue_mode && prio_result == QSUF_PRIO_3 |=> queue_high)
        else $error("result 3 not sent to the high queue");
    a_result0_low: assert property (
        prio_valid && two_queue_mode && prio_result == 2'h0 |=> queue_valid && !queue_high)
        else $error("result 0 not sent to the low queue");

endmodule

`default_nettype wire

// ---- test/tb_qsuf_cfg.sv ----
// testbench: register access, queue fold and unknown-destination forwarding of qsuf_cfg
`timescale 1ns/100ps
`default_nettype none

module tb_qsuf_cfg;
    import qsuf_pkg::*;

    logic       clk, rst, wr_en, rd_en, two_queue_mode, prio_valid, uu_lookup, um_lookup;
    logic [7:0] addr, wr_data, rd_data;
    logic [1:0] prio_result;
    logic       queue_valid, queue_high, uu_valid, uu_drop, um_valid, um_drop;
    logic [4:0] uu_port_map, um_port_map;
    logic [1:0] sel_m;
    logic [5:0] uu_m, um_m;
    logic [7:0] rq[$];
    logic       qq[$];
    logic [5:0] uq[$], mq[$];
    integer     seed, n_errors, total_checks;
    logic       took;
    logic [7:0] r;
    logic [4:0] maps [6] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F};

    qsuf_cfg dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .two_queue_mode(two_queue_mode),
        .prio_valid(prio_valid), .prio_result(prio_result), .queue_valid(queue_valid),
        .queue_high(queue_high), .uu_lookup(uu_lookup), .uu_valid(uu_valid),
        .uu_port_map(uu_port_map), .uu_drop(uu_drop), .um_lookup(um_lookup),
        .um_valid(um_valid), .um_port_map(um_port_map), .um_drop(um_drop));

    // ========================================================================
    // clock, comparison and verdict
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", name, e, g);
            n_errors++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ========================================================================
    // driver: one request cycle, every input but clk and rst assigned once per edge
    task automatic put(input logic w, input logic rr, input logic [7:0] a, input logic [7:0] d,
                       input logic tq, input logic pv, input logic [1:0] pr,
                       input logic ul, input logic ml);
        @(posedge clk);
        wr_en <= w;
        rd_en <= rr;
        addr <= a;
        wr_data <= d;
        two_queue_mode <= tq;
        prio_valid <= pv;
        prio_result <= pr;
        uu_lookup <= ul;
        um_lookup <= ml;
    endtask

    task automatic idle();
        put(0, 0, 8'h00, 8'h00, 1, 0, 2'h0, 0, 0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put(1, 0, a, d, 1, 0, 2'h0, 0, 0);
        if (a == QSUF_ADDR_SPLIT) sel_m = d[7:6];
        else if (a == QSUF_ADDR_UU) uu_m = d[5:0];
        else if (a == QSUF_ADDR_UM) um_m = d[5:0];
    endtask

    task automatic rd(input logic [7:0] a);
        if (a == QSUF_ADDR_SPLIT) rq.push_back({sel_m, 6'h08});
        else if (a == QSUF_ADDR_UU) rq.push_back({2'h2, uu_m});
        else if (a == QSUF_ADDR_UM) rq.push_back({2'h1, um_m});
        else rq.push_back(8'h00);
        put(0, 1, a, 8'h00, 1, 0, 2'h0, 0, 0);
    endtask

    task automatic fold(input logic tq, input logic [1:0] pr);
        if (tq) qq.push_back((sel_m == 2'h0) ? (pr == 2'h3) :
                             (sel_m == 2'h2) ? (pr >= 2'h2) : (pr != 2'h0));
        put(0, 0, 8'h00, 8'h00, tq, 1, pr, 0, 0);
    endtask

    function automatic logic [5:0] fwd(input logic [5:0] cfg);
        return cfg[5] ? {cfg[4:0] == 5'h00, cfg[4:0]} : {1'b0, 5'h1F};
    endfunction

    task automatic look(input logic ul, input logic ml);
        if (ul) uq.push_back(fwd(uu_m));
        if (ml) mq.push_back(fwd(um_m));
        put(0, 0, 8'h00, 8'h00, 1, 0, 2'h0, ul, ml);
    endtask

    task automatic do_reset();
        idle();
        rst <= 1'b1;
        repeat (6) idle();
        rst <= 1'b0;
        sel_m = 2'h2;
        uu_m = 6'h00;
        um_m = 6'h00;
    endtask

    // ========================================================================
    // monitor: each answer takes the oldest note of its stream
    initial begin
        forever begin
            @(posedge clk);
            took = rd_en && !rst;
            @(negedge clk);
            if (took) chk("rd_data", rq.size() ? rq.pop_front() : 8'hXX, rd_data);
            else chk("rd_data idle", 8'h00, rd_data);
            if (queue_valid)
                chk("queue_high", qq.size() ? {7'h00, qq.pop_front()} : 8'hXX,
                    {7'h00, queue_high});
            else chk("queue idle", 8'h00, {7'h00, queue_high});
            if (uu_valid) chk("uu map", uq.size() ? {2'h0, uq.pop_front()} : 8'hXX,
                              {2'h0, uu_drop, uu_port_map});
            else chk("uu idle", 8'h00, {2'h0, uu_drop, uu_port_map});
            if (um_valid) chk("um map", mq.size() ? {2'h0, mq.pop_front()} : 8'hXX,
                              {2'h0, um_drop, um_port_map});
            else chk("um idle", 8'h00, {2'h0, um_drop, um_port_map});
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        conclude();
    end

    // ========================================================================
    // stimulus
    initial begin
        seed = 83137;
        n_errors = 0;
        total_checks = 0;
        {rst, wr_en, rd_en, prio_valid, uu_lookup, um_lookup} = 6'h00;
        {addr, wr_data, prio_result} = 18'h00000;
        two_queue_mode = 1'b1;
        do_reset();
        for (int i = 0; i < 6; i++) rd(8'h81 + 8'(i));
        for (int p = 0; p < 4; p++) fold(1, 2'(p));
        fold(0, 2'h3);
        look(1, 1);
        foreach (maps[i]) begin
            r = 8'($random(seed));
            wr(QSUF_ADDR_UU, {r[7:6], 1'b1, maps[i]});
            wr(QSUF_ADDR_UM, {r[5:4], 1'b1, maps[5 - i]});
            rd(QSUF_ADDR_UU);
            rd(QSUF_ADDR_UM);
            look(1, 1);
        end
        for (int s = 0; s < 3; s++) begin
            r = 8'($random(seed));
            wr(QSUF_ADDR_SPLIT, {(s == 0) ? 2'h0 : (s == 1) ? 2'h3 : 2'h2, r[5:0]});
            rd(QSUF_ADDR_SPLIT);
            for (int p = 0; p < 4; p++) fold(1, 2'(p));
        end
        wr(8'h81, 8'($random(seed)));
        wr(8'h85, 8'($random(seed)));
        for (int i = 0; i < 3; i++) rd(QSUF_ADDR_SPLIT + 8'(i));
        repeat (80) begin
            r = 8'($random(seed));
            case (r[1:0])
                2'h0: fold(r[2], r[4:3]);
                2'h1: look(r[2], r[3]);
                2'h2: wr(QSUF_ADDR_SPLIT + 8'(r[3:2] % 3),
                         (r[7:6] == 2'h1) ? {2'h3, r[5:0]} : r);
                default: rd(QSUF_ADDR_SPLIT + 8'(r[3:2] % 3));
            endcase
        end
        do_reset();
        for (int i = 0; i < 3; i++) rd(QSUF_ADDR_SPLIT + 8'(i));
        look(1, 1);
        repeat (4) idle();
        chk("pending notes", 8'h00, 8'(rq.size() + qq.size() + uq.size() + mq.size()));
        conclude();
    end
endmodule

`default_nettype wire
